// >>> logic/amp_audio_port_state_diag_regs.sv
/*
  control and status register group of a two-channel amplifier:
  audio port setup, channel state requests, level ramping and the
  dc load check controls and first report.
  assumes a control port front end that presents byte writes and
  reads on the reference clock, a load check engine on the same
  clock, and a frame sync pin from outside that is synchronised here.
*/
`timescale 1ns/100ps
`include "amp_regs_defs.svh"

module amp_audio_port_state_diag_regs #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_reset,
  // control port register access
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  input  wire logic [7:0]                   i_reg_addr,
  input  wire logic [7:0]                   i_reg_wdata,
  output logic      [7:0]                   o_reg_rdata,
  output logic                              o_reg_ack,
  // audio port side
  input  wire logic                         i_frame_sync,
  input  wire logic [1:0]                   i_level_step_rate,
  output amp_regs_pkg::port_setup_t         o_port_setup,
  output logic      [1:0][7:0]              o_level_now,
  output logic      [1:0]                   o_chan_mute,
  output logic      [1:0][1:0]              o_chan_state_request,
  // load check engine side
  input  wire logic                         i_check_busy,
  input  wire logic                         i_check_done,
  input  wire logic [7:0]                   i_check_flags,
  input  wire logic                         i_chan_fault,
  output amp_regs_pkg::check_setup_t        o_check_setup,
  output logic                              o_auto_check_start
);

  // the level ramp and slot math are written for exactly two channels
  if (CHANNELS != 2)
  begin : g_channel_check
    $error("only two channels are supported");
  end

  amp_regs_pkg::state_t s;
  amp_regs_pkg::state_t next_s;
  logic                 fs_edge;
  logic                 step_due;
  logic [1:0]           leave_hiz;
  logic [2:0]           step_span;

  // a frame sync edge is seen on the second synchroniser stage only
  assign fs_edge   = s.fs_sync & ~s.fs_prev;
  assign step_span = 3'((4'h1 << i_level_step_rate) - 4'h1);
  assign step_due  = fs_edge && (s.fs_count >= step_span);

  // next state of everything
  always_comb
  begin
    next_s            = s;
    next_s.ack        = i_reg_rd;
    next_s.auto_start = 1'b0;
    leave_hiz         = 2'b00;

    // pin crossing, then edge memory
    next_s.fs_meta = i_frame_sync;
    next_s.fs_sync = s.fs_meta;
    next_s.fs_prev = s.fs_sync;

    // frame sync divider for the level ramp
    if (fs_edge)
    begin
      next_s.fs_count = step_due ? 3'h0 : 3'(s.fs_count + 3'h1);
    end

    // ramp each channel one code toward its setting
    for (int ch = 0; ch < 2; ch++)
    begin
      if (step_due && (s.level_now[ch] < s.level_set[ch]))
      begin
        next_s.level_now[ch] = 8'(s.level_now[ch] + 8'h01);
      end
      else if (step_due && (s.level_now[ch] > s.level_set[ch]))
      begin
        next_s.level_now[ch] = 8'(s.level_now[ch] - 8'h01);
      end
    end

    // cancel drops once the engine has stopped
    if (s.check_ctrl[`BIT_CANCEL] && !i_check_busy)
    begin
      next_s.check_ctrl[`BIT_CANCEL] = 1'b0;
    end

    if (i_check_done)
    begin
      next_s.check_res = i_check_flags;
    end

    // register writes; a write coming after the clear above wins
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        `OFS_PORT_CFG:
        begin
          // reserved rate code leaves the field alone
          if (i_reg_wdata[7:6] != `RATE_RESERVED)
          begin
            next_s.port_cfg[7:6] = i_reg_wdata[7:6];
          end
          next_s.port_cfg[5:3] = i_reg_wdata[5:3];
          // reserved format code leaves the field alone
          if (i_reg_wdata[2:0] != `FMT_RESERVED)
          begin
            next_s.port_cfg[2:0] = i_reg_wdata[2:0];
          end
        end
        `OFS_STATE_REQ:
        begin
          next_s.state_req = i_reg_wdata;
          leave_hiz[0] = (s.state_req[7:6] == `STATE_HIZ) &&
                         (i_reg_wdata[7:6] != `STATE_HIZ);
          leave_hiz[1] = (s.state_req[5:4] == `STATE_HIZ) &&
                         (i_reg_wdata[5:4] != `STATE_HIZ);
        end
        `OFS_LEVEL1:
        begin
          next_s.level_set[0] = i_reg_wdata;
        end
        `OFS_LEVEL2:
        begin
          next_s.level_set[1] = i_reg_wdata;
        end
        `OFS_CHECK_CTRL:
        begin
          next_s.check_ctrl = (i_reg_wdata & `CTRL_RW_MASK) |
                              (next_s.check_ctrl & 8'h80);
          // a new cancel request is never lost
          if (!i_reg_wdata[`BIT_CANCEL] && !s.check_ctrl[`BIT_CANCEL])
          begin
            next_s.check_ctrl[`BIT_CANCEL] = 1'b0;
          end
        end
        `OFS_CHECK_THR:
        begin
          // codes above nine are reserved and ignored
          if (i_reg_wdata[7:4] <= `THR_MAX)
          begin
            next_s.check_thr[7:4] = i_reg_wdata[7:4];
          end
          if (i_reg_wdata[3:0] <= `THR_MAX)
          begin
            next_s.check_thr[3:0] = i_reg_wdata[3:0];
          end
        end
        default:
        begin
          // read-only and unmapped offsets ignore writes
          next_s.port_cfg = next_s.port_cfg;
        end
      endcase
    end

    next_s.auto_start = !s.check_ctrl[`BIT_AUTO_SKIP] &&
                        ((|leave_hiz) || i_chan_fault);

    // read data, one cycle after the strobe; unmapped reads zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `OFS_PORT_CFG:   next_s.rdata = s.port_cfg;
        `OFS_STATE_REQ:  next_s.rdata = s.state_req;
        `OFS_LEVEL1:     next_s.rdata = s.level_set[0];
        `OFS_LEVEL2:     next_s.rdata = s.level_set[1];
        `OFS_CHECK_CTRL: next_s.rdata = s.check_ctrl;
        `OFS_CHECK_THR:  next_s.rdata = s.check_thr;
        `OFS_CHECK_RES:  next_s.rdata = s.check_res;
        default:         next_s.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s.port_cfg   <= `RST_PORT_CFG;
      // both channels start in high impedance
      s.state_req  <= `RST_STATE_REQ;
      s.level_set  <= {`RST_LEVEL, `RST_LEVEL};
      s.level_now  <= {`RST_LEVEL, `RST_LEVEL};
      s.check_ctrl <= `RST_CHECK_CTRL;
      s.check_thr  <= `RST_CHECK_THR;
      s.check_res  <= `RST_CHECK_RES;
      s.rdata      <= 8'h00;
      s.ack        <= 1'b0;
      s.auto_start <= 1'b0;
      s.fs_meta    <= 1'b0;
      s.fs_sync    <= 1'b0;
      s.fs_prev    <= 1'b0;
      s.fs_count   <= 3'h0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs are all taken from state flops or plain decodes of them
  assign o_reg_rdata          = s.rdata;
  assign o_reg_ack            = s.ack;
  assign o_level_now          = s.level_now;
  assign o_auto_check_start   = s.auto_start;
  assign o_chan_state_request = {s.state_req[5:4], s.state_req[7:6]};

  // mute below audible code, one decode per channel
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_mute
    assign o_chan_mute[ch] = s.level_now[ch] < `LEVEL_MUTE_LT;
  end

  // rate and format passed on as coded
  assign o_port_setup.frame_rate_select    = s.port_cfg[7:6];
  assign o_port_setup.data_format          = s.port_cfg[2:0];
  assign o_port_setup.eight_slot_half_pick = s.port_cfg[5];
  assign o_port_setup.short_slots          = s.port_cfg[4];
  assign o_port_setup.chan1_slot = {s.port_cfg[5], s.port_cfg[3], 1'b0};
  assign o_port_setup.chan2_slot = {s.port_cfg[5], s.port_cfg[3], 1'b1};

  assign o_check_setup.load_check_cancel     = s.check_ctrl[`BIT_CANCEL];
  assign o_check_setup.double_ramp_time      = s.check_ctrl[`BIT_DBL_RAMP];
  assign o_check_setup.double_settle_time    = s.check_ctrl[`BIT_DBL_SETTLE];
  assign o_check_setup.line_out_check_on     = s.check_ctrl[`BIT_LINE_OUT];
  assign o_check_setup.chan1_short_threshold = s.check_thr[7:4];
  assign o_check_setup.chan2_short_threshold = s.check_thr[3:0];

  // checks on the register behaviour
  AST_PORT_RESET: assert property (
    @(posedge i_ref_clk) $fell(i_reset) |-> (o_port_setup.data_format == 3'h4 &&
      o_port_setup.frame_rate_select == 2'h0 && !o_port_setup.short_slots))
    else $error("port setup not at its reset value");

  AST_RATE_RESERVED: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_PORT_CFG && i_reg_wdata[7:6] == 2'h3)
    |=> (o_port_setup.frame_rate_select == $past(o_port_setup.frame_rate_select)))
    else $error("reserved rate code was stored");

  AST_FMT_RESERVED: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_PORT_CFG && i_reg_wdata[2:0] == 3'h7)
    |=> (o_port_setup.data_format == $past(o_port_setup.data_format)))
    else $error("reserved format code was stored");

  AST_SLOT_SWAP: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_PORT_CFG) |=>
    (o_port_setup.chan1_slot == {$past(i_reg_wdata[5]), $past(i_reg_wdata[3]), 1'b0}))
    else $error("slot mapping does not follow the written bits");

  AST_STATE_RESET: assert property (
    @(posedge i_ref_clk) $fell(i_reset) |-> (o_chan_state_request == 4'h5))
    else $error("channels not in high impedance after reset");

  AST_LEVEL2_WRITE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_LEVEL2) ##1 !i_reg_wr ##1
    (i_reg_rd && i_reg_addr == `OFS_LEVEL2) |=> (o_reg_rdata == $past(i_reg_wdata, 3)))
    else $error("channel 2 level did not read back");

  AST_MUTE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_chan_mute[0] == (o_level_now[0] < 8'h07))
    else $error("mute does not match the level code");

  AST_RAMP_ONE_STEP: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    $changed(o_level_now[0]) |-> ($past(fs_edge) &&
      (o_level_now[0] - $past(o_level_now[0]) == 8'h01 ||
       $past(o_level_now[0]) - o_level_now[0] == 8'h01)))
    else $error("level moved by more than one step or off a frame sync");

  AST_CANCEL_HOLD: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_check_setup.load_check_cancel && i_check_busy) |=> o_check_setup.load_check_cancel)
    else $error("cancel dropped while the check still runs");

  AST_REPORT_CAPTURE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_check_done && !i_reg_rd) ##1 (i_reg_rd && i_reg_addr == `OFS_CHECK_RES && !i_check_done)
    |=> (o_reg_rdata == $past(i_check_flags, 2)))
    else $error("report does not hold the finished check flags");

  AST_AUTO_SKIP: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_auto_check_start |-> !$past(s.check_ctrl[`BIT_AUTO_SKIP]))
    else $error("automatic check started while skipped");

  AST_THR_RANGE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_check_setup.chan1_short_threshold <= 4'h9) &&
    (o_check_setup.chan2_short_threshold <= 4'h9))
    else $error("threshold holds a reserved code");

  AST_STATE_WRITE: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_STATE_REQ) |=>
    (o_chan_state_request == {$past(i_reg_wdata[5:4]), $past(i_reg_wdata[7:6])}))
    else $error("channel state request does not follow the write");

  AST_CANCEL_SET: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == `OFS_CHECK_CTRL && i_reg_wdata[`BIT_CANCEL]) |=>
    o_check_setup.load_check_cancel)
    else $error("cancel request was lost");

  AST_CTRL_RESERVED: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_reg_ack && $past(i_reg_addr) == `OFS_CHECK_CTRL) |-> (o_reg_rdata[4:2] == 3'h0))
    else $error("reserved control bits read back set");

  AST_AUTO_ON_FAULT: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_chan_fault && !s.check_ctrl[`BIT_AUTO_SKIP]) |=> o_auto_check_start)
    else $error("channel fault did not start an automatic check");

endmodule

// >>> logic/amp_regs_defs.svh
/*
  constants of the amplifier control and status register group:
  offsets, reset values, field positions and decode limits.
  assumes it is included by bare name from the register block.
*/
// How it works
// - port configuration resets to 0x04: 44.1 kHz, I2S, wide slots, first slots, no swap.
// - rate field bits 7-6: 00 44.1, 01 48, 10 96 kHz; 11 reserved.
// - bit 5 picks first or last four slots in eight-slot TDM.
// - bit 4 sets slot width: 0 is 24/32-bit, 1 is 16-bit.
// - bit 3 set swaps channels 1/2 onto the data of channels 3/4.
// - format field decodes right justified widths, I2S, left justified, DSP; 111 reserved.
// - per-channel state request: 00 play, 01 high-Z, 10 mute, 11 diagnostics.
// - state request register resets to 0x55, both channels high impedance.
// - per-channel 8-bit level in half-dB steps, resets 0xcf, below 0x07 mutes.
// - channel 1 level at offset 0x05, channel 2 level at 0x06.
// - writing cancel bit aborts a running check; bit clears once abort completes.
// - bit 6 doubles ramp time, bit 5 doubles settle time.
// - bit 1 enables line-output detection during load checks.
// - bit 0 low runs checks automatically on leaving high-Z or after faults.
// - shorted-load thresholds map code n to (n+1) half ohms; both reset 0001.
// - read-only report at 0x0c holds four flags per channel, resetting to zero.
// - a report flag reads 1 exactly when the check found that fault.
// - level moves one step per 1, 2, 4 or 8 frame syncs.
`ifndef AMP_REGS_DEFS_SVH
`define AMP_REGS_DEFS_SVH

`define OFS_PORT_CFG    8'h03
`define OFS_STATE_REQ   8'h04
`define OFS_LEVEL1      8'h05
`define OFS_LEVEL2      8'h06
`define OFS_CHECK_CTRL  8'h09
`define OFS_CHECK_THR   8'h0a
`define OFS_CHECK_RES   8'h0c

`define RST_PORT_CFG    8'h04
`define RST_STATE_REQ   8'h55
`define RST_LEVEL       8'hcf
`define RST_CHECK_CTRL  8'h00
`define RST_CHECK_THR   8'h11
`define RST_CHECK_RES   8'h00

`define RATE_RESERVED   2'h3
`define FMT_RESERVED    3'h7
`define STATE_HIZ       2'h1
`define LEVEL_MUTE_LT   8'h07
`define THR_MAX         4'h9
`define CTRL_RW_MASK    8'he3
`define BIT_CANCEL      7
`define BIT_DBL_RAMP    6
`define BIT_DBL_SETTLE  5
`define BIT_LINE_OUT    1
`define BIT_AUTO_SKIP   0

`endif

// >>> logic/amp_regs_pkg.sv
/*
  types of the amplifier control and status register group.
  assumes the defs header sits beside it.
*/
package amp_regs_pkg;

  // all state of the register block
  typedef struct packed {
    logic [7:0]      port_cfg;
    logic [7:0]      state_req;
    logic [1:0][7:0] level_set;
    logic [1:0][7:0] level_now;
    logic [7:0]      check_ctrl;
    logic [7:0]      check_thr;
    logic [7:0]      check_res;
    logic [7:0]      rdata;
    logic            ack;
    logic            auto_start;
    logic            fs_meta;
    logic            fs_sync;
    logic            fs_prev;
    logic [2:0]      fs_count;
  } state_t;

  // decoded audio port setup handed to the datapath
  typedef struct packed {
    logic [1:0] frame_rate_select;
    logic [2:0] data_format;
    logic       eight_slot_half_pick;
    logic       short_slots;
    logic [2:0] chan1_slot;
    logic [2:0] chan2_slot;
  } port_setup_t;

  // load check controls handed to the diagnostic engine
  typedef struct packed {
    logic       load_check_cancel;
    logic       double_ramp_time;
    logic       double_settle_time;
    logic       line_out_check_on;
    logic [3:0] chan1_short_threshold;
    logic [3:0] chan2_short_threshold;
  } check_setup_t;

endpackage

// >>> test/amp_audio_port_state_diag_regs_test.sv
/*
  self-checking bench for the amplifier register group: reset values,
  port setup decode, state requests, automatic check start, load check
  controls, thresholds, report capture and level ramping.
  assumes the bench alone drives every port of the block on one clock.
*/
`timescale 1ns/100ps

module amp_audio_port_state_diag_regs_test;

  logic                      clk, rst, wr, rd, fs, busy, done, fault, start_seen;
  logic [7:0]                addr, wdata, flags, rdata, v, s;
  logic [1:0]                step_rate;
  logic                      ack, auto_start;
  logic [1:0][7:0]           level_now;
  logic [1:0]                mute;
  logic [1:0][1:0]           state_req;
  amp_regs_pkg::port_setup_t  port_setup;
  amp_regs_pkg::check_setup_t check_setup;
  logic [7:0]                rd_q[$];
  int                        fails, num_checks;
  int unsigned               seed_dummy;

  amp_audio_port_state_diag_regs i_amp_audio_port_state_diag_regs (
    .i_ref_clk            (clk),
    .i_reset              (rst),
    .i_reg_wr             (wr),
    .i_reg_rd             (rd),
    .i_reg_addr           (addr),
    .i_reg_wdata          (wdata),
    .o_reg_rdata          (rdata),
    .o_reg_ack            (ack),
    .i_frame_sync         (fs),
    .i_level_step_rate    (step_rate),
    .o_port_setup         (port_setup),
    .o_level_now          (level_now),
    .o_chan_mute          (mute),
    .o_chan_state_request (state_req),
    .i_check_busy         (busy),
    .i_check_done         (done),
    .i_check_flags        (flags),
    .i_chan_fault         (fault),
    .o_check_setup        (check_setup),
    .o_auto_check_start   (auto_start)
  );

  // free-running 40 MHz reference
  always #12.5 clk = ~clk;

  task automatic final_report;
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data is checked by the monitor, so the note goes on the queue first
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // the start pulse stands one cycle only, so it is caught inside the task
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    start_seen = auto_start;
    @(posedge clk);
    #1;
  endtask

  task automatic fault_pulse(input logic exp);
    fault = 1'b1;
    @(posedge clk);
    #1;
    fault = 1'b0;
    cmp("fault start", {7'h00, exp}, {7'h00, auto_start});
    @(posedge clk);
    #1;
  endtask

  // pulses are spaced wider than the two-flop synchroniser needs
  task automatic sync_pulses(input int n);
    repeat (n)
    begin
      fs = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      fs = 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic check_port(input logic [7:0] x);
    cmp("rate", {6'h00, x[7:6]}, {6'h00, port_setup.frame_rate_select});
    cmp("format", {5'h00, x[2:0]}, {5'h00, port_setup.data_format});
    cmp("half pick", {7'h00, x[5]}, {7'h00, port_setup.eight_slot_half_pick});
    cmp("slot size", {7'h00, x[4]}, {7'h00, port_setup.short_slots});
    cmp("ch1 slot", {5'h00, x[5], x[3], 1'b0}, {5'h00, port_setup.chan1_slot});
    cmp("ch2 slot", {5'h00, x[5], x[3], 1'b1}, {5'h00, port_setup.chan2_slot});
  endtask

  // read monitor: every ack takes the oldest note
  always @(posedge clk)
    if (ack === 1'b1)
    begin
      if (rd_q.size() == 0)
        cmp("spare ack", 8'h00, 8'h01);
      else
        cmp("read data", rd_q.pop_front(), rdata);
    end

  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end

  initial
  begin
    {clk, wr, rd, fs, busy, done, fault, start_seen} = '0;
    {addr, wdata, flags, v, s, step_rate} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    seed_dummy = $urandom(68161);
    reg_read(8'h03, 8'h04);
    check_port(8'h04);
    reg_read(8'h04, 8'h55);
    reg_read(8'h05, 8'hcf);
    reg_read(8'h06, 8'hcf);
    reg_read(8'h09, 8'h00);
    reg_read(8'h0a, 8'h11);
    reg_read(8'h0c, 8'h00);
    reg_read(8'h0d, 8'h00);
    cmp("level ch1", 8'hcf, level_now[0]);
    // random setups, then reserved codes leave fields alone
    for (int k = 0; k < 8; k++)
    begin
      v = 8'($urandom);
      if (v[7:6] == 2'h3)
        v[7:6] = 2'h2;
      if (v[2:0] == 3'h7)
        v[2:0] = 3'h6;
      reg_write(8'h03, v);
      reg_read(8'h03, v);
      check_port(v);
      reg_write(8'h03, {2'h3, v[5:0]});
      reg_write(8'h03, {v[7:3], 3'h7});
      reg_read(8'h03, v);
    end
    // every code on each channel, start only when leaving high-Z
    for (int ch = 0; ch < 2; ch++)
      for (int c = 0; c < 4; c++)
      begin
        s = ch ? {2'h1, 2'(c), 4'h5} : {2'(c), 2'h1, 4'h5};
        reg_write(8'h04, 8'h55);
        reg_write(8'h04, s);
        cmp("auto start", {7'h00, c != 1}, {7'h00, start_seen});
        cmp("state", 8'(c), {6'h00, state_req[ch]});
        reg_read(8'h04, s);
      end
    fault_pulse(1'b1);
    // control bits; cancel holds while the check runs
    busy = 1'b1;
    reg_write(8'h09, 8'hff);
    reg_read(8'h09, 8'he3);
    cmp("check ctrl", 8'h0f, {4'h0, check_setup[11:8]});
    reg_write(8'h04, 8'h55);
    reg_write(8'h04, 8'h15);
    cmp("skip start", 8'h00, {7'h00, start_seen});
    fault_pulse(1'b0);
    busy = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reg_read(8'h09, 8'h63);
    reg_write(8'h09, 8'h00);
    cmp("check ctrl", 8'h00, {4'h0, check_setup[11:8]});
    // thresholds, top legal code then an out-of-range nibble
    reg_write(8'h0a, 8'h90);
    reg_read(8'h0a, 8'h90);
    reg_write(8'h0a, 8'ha3);
    reg_read(8'h0a, 8'h93);
    cmp("thresholds", 8'h93, check_setup[7:0]);
    // report captured on done, host writes ignored
    flags = 8'($urandom);
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
    reg_read(8'h0c, flags);
    reg_write(8'h0c, ~flags);
    reg_read(8'h0c, flags);
    // ramp down to the mute boundary at one step per sync
    reg_write(8'h05, 8'h05);
    reg_read(8'h05, 8'h05);
    sync_pulses(200);
    cmp("level ch1", 8'h07, level_now[0]);
    cmp("mute", 8'h00, {6'h00, mute});
    sync_pulses(2);
    cmp("level ch1", 8'h05, level_now[0]);
    cmp("mute", 8'h01, {6'h00, mute});
    cmp("level ch2", 8'hcf, level_now[1]);
    // slower rate: one step in any two syncs
    step_rate = 2'h1;
    reg_write(8'h06, 8'hd1);
    reg_read(8'h06, 8'hd1);
    sync_pulses(2);
    cmp("level ch2", 8'hd0, level_now[1]);
    sync_pulses(2);
    cmp("level ch2", 8'hd1, level_now[1]);
    // slowest rates: four and then eight syncs to a step
    step_rate = 2'h2;
    reg_write(8'h06, 8'hd0);
    sync_pulses(3);
    cmp("level ch2", 8'hd1, level_now[1]);
    sync_pulses(1);
    cmp("level ch2", 8'hd0, level_now[1]);
    step_rate = 2'h3;
    reg_write(8'h06, 8'hd1);
    sync_pulses(7);
    cmp("level ch2", 8'hd0, level_now[1]);
    sync_pulses(1);
    cmp("level ch2", 8'hd1, level_now[1]);
    repeat (4) @(posedge clk);
    if (rd_q.size() != 0)
      fails++;
    final_report();
  end

endmodule
